// ==== vram_ctl.sv ====
// Host-side controller driving the random-access port of a dual-port video DRAM
`timescale 1ns/1ps
// Function
// R1: Device keeps read data after column strobe
// R2: Reads, writes allowed in extended output mode
// R3: Separate lower and upper byte write strobes
// R4: Masked write: column high, write/select low
// R5: Mask zero blocks bit, one allows
// R6: New mask must be resent every row
// R7: Data sampled on later falling strobe edge
// R8: Both byte strobes high means no masking
// R9: High byte strobe skips that byte
// R10: Mask load: select, write high; select low
// R11: Mask load enters old mask mode
// R12: Mask register changes only on load
// R13: Option-reset refresh restores new mask mode
// R14: Page mode: row held, column cycled; not used here, one column strobe per row cycle
// R15: Color load: select high both strobe falls
// R16: Block write fills eight columns per bit
// R17: Block write ignores three low column bits
// R18: Block data pins are column enables
// R19: Masked block: select, write low first
// R20: Outputs float when output enable high
// R21: Refresh all 512 rows every 8 ms
// R22: Row-only refresh keeps column strobe high
// R23: Column-first refresh, select low resets options
// R24: Read keeps write enable high throughout
// R25: Device keeps one mask-mode bit
module vram_ctl
    import vram_ctl_pkg::*;
#(
    parameter int REFRESH_CYCLES = vram_ctl_pkg::REFRESH_INTERVAL  // Shorten for simulation
) (
    input  wire logic                              mclk,
    input  wire logic                              rst_n,
    // User side
    input  wire logic                              req_valid,
    output logic                                   req_ready,
    input  wire vram_ctl_pkg::cmd_t                req_cmd,
    input  wire logic [vram_ctl_pkg::ROW_W-1:0]    req_row,
    input  wire logic [vram_ctl_pkg::ADDR_W-1:0]   req_col,
    input  wire logic [vram_ctl_pkg::DATA_W-1:0]   req_mask,
    input  wire logic [vram_ctl_pkg::DATA_W-1:0]   req_data,
    input  wire logic [1:0]                        req_lanes,
    output logic                                   rd_valid,
    output logic [vram_ctl_pkg::DATA_W-1:0]        rd_data,
    // Device pins
    output logic                                   row_strobe_n,
    output logic                                   col_strobe_n,
    output logic                                   write_enable_or_mask_select_n,
    output logic                                   lower_byte_write_strobe_n,
    output logic                                   upper_byte_write_strobe_n,
    output logic                                   transfer_or_output_enable_n,
    output logic                                   special_function_select,
    output logic [vram_ctl_pkg::ADDR_W-1:0]        addr,
    input  wire logic [vram_ctl_pkg::DATA_W-1:0]   mask_and_data_pins_in,
    output logic [vram_ctl_pkg::DATA_W-1:0]        mask_and_data_pins_out,
    output logic                                   mask_and_data_pins_oe_n
);
    // ==========================================================
    // Phases of one access
    typedef enum logic [2:0] {S_IDLE, S_ROW, S_COL, S_HOLD, S_PRE} state_t;

    state_t                state_q, state_d;            // Sequencer state
    logic [7:0]            cnt_q, cnt_d;                // Phase timer
    cmd_t                  cmd_q, cmd_d;                // Command in flight
    logic [ROW_W-1:0]      row_q, row_d;
    logic [ADDR_W-1:0]     col_q, col_d;
    logic [DATA_W-1:0]     mask_q, mask_d, data_q, data_d;
    logic [1:0]            lanes_q, lanes_d;
    logic                  refr_q, refr_d;              // Current cycle is a refresh
    logic [ROW_W-1:0]      rrow_q, rrow_d;              // Next row to refresh
    logic [31:0]           rtmr_q, rtmr_d;              // Refresh interval timer
    logic                  rpend_q, rpend_d;            // Refresh owed
    logic [DATA_W-1:0]     sync1_q, sync2_q;            // Read data synchroniser
    logic                  rdv_q, rdv_d;
    logic [DATA_W-1:0]     rdd_q, rdd_d;
    logic                  step_done;

    assign step_done = (cnt_q == 8'(STEP_CYCLES - 1));

    // Two flops on the data pins before anything looks at them
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 16'h0000;
            sync2_q <= 16'h0000;
        end else begin
            sync1_q <= mask_and_data_pins_in;
            sync2_q <= sync1_q;
        end
    end

    // ==========================================================
    // Sequencer next state
    always_comb begin
        state_d = state_q;
        cnt_d   = step_done ? 8'h00 : cnt_q + 8'h01;
        cmd_d = cmd_q; row_d = row_q; col_d = col_q; mask_d = mask_q;
        data_d = data_q; lanes_d = lanes_q; refr_d = refr_q; rrow_d = rrow_q;
        rdv_d = 1'b0;
        rdd_d = rdd_q;
        // Refresh timer runs freely; a refresh is owed each interval [R21]
        rpend_d = rpend_q;
        rtmr_d  = rtmr_q + 32'h0000_0001;
        if (rtmr_q >= 32'(REFRESH_CYCLES - 1)) begin
            rtmr_d  = 32'h0000_0000;
            rpend_d = 1'b1;
        end
        case (state_q)
            S_IDLE: begin
                cnt_d = 8'h00;
                if (rpend_q) begin
                    // Row-only refresh wins over user work [R21] [R22]
                    refr_d  = 1'b1;
                    row_d   = rrow_q;
                    rrow_d  = rrow_q + 9'h001;
                    rpend_d = 1'b0;
                    state_d = S_ROW;
                end else if (req_valid) begin
                    refr_d = 1'b0;
                    cmd_d = req_cmd; row_d = req_row; mask_d = req_mask;
                    data_d = req_data; lanes_d = req_lanes;
                    // Block writes drop the low three column bits [R17]
                    col_d = (req_cmd == CMD_BLOCK_WRITE || req_cmd == CMD_MASKED_BLOCK)
                            ? (req_col & BLOCK_COL_MASK) : req_col;
                    state_d = S_ROW;
                end
            end
            S_ROW:  if (step_done) state_d = (refr_q || cmd_q == CMD_OPTION_RESET) ? S_HOLD : S_COL;
            S_COL:  if (step_done) state_d = S_HOLD;
            S_HOLD: if (step_done) begin
                // Capture read data at end of hold phase, column strobe still low [R24]
                if (!refr_q && cmd_q == CMD_READ) begin
                    rdv_d = 1'b1;
                    rdd_d = sync2_q;
                end
                state_d = S_PRE;
            end
            S_PRE:  if (step_done) state_d = S_IDLE;
            default: state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= S_IDLE; cnt_q <= 8'h00; cmd_q <= CMD_READ;
            row_q <= 9'h000; col_q <= 9'h000; mask_q <= 16'h0000; data_q <= 16'h0000;
            lanes_q <= 2'b00; refr_q <= 1'b0; rrow_q <= 9'h000; rtmr_q <= 32'h0000_0000;
            rpend_q <= 1'b0; rdv_q <= 1'b0; rdd_q <= 16'h0000;
        end else begin
            state_q <= state_d; cnt_q <= cnt_d; cmd_q <= cmd_d;
            row_q <= row_d; col_q <= col_d; mask_q <= mask_d; data_q <= data_d;
            lanes_q <= lanes_d; refr_q <= refr_d; rrow_q <= rrow_d; rtmr_q <= rtmr_d;
            rpend_q <= rpend_d; rdv_q <= rdv_d; rdd_q <= rdd_d;
        end
    end

    // ==========================================================
    // Pin levels per phase
    logic row_low, col_low, is_write, sel_at_row, sel_at_col, we_at_row, masked;
    always_comb begin
        // Strobes fall one cycle into their phase, once address, select and data have settled
        row_low  = (state_q == S_ROW && cnt_q != 8'h00) || state_q == S_COL || state_q == S_HOLD;
        // Column strobe falls once while the row strobe is held low; no page-mode cycling [R14]
        col_low  = ((state_q == S_COL && cnt_q != 8'h00) || state_q == S_HOLD) && !refr_q;
        masked   = (cmd_q == CMD_MASKED_WRITE || cmd_q == CMD_MASKED_BLOCK);
        is_write = !refr_q && cmd_q != CMD_READ && cmd_q != CMD_OPTION_RESET;
        // Select at row fall: high for mask and color loads [R10] [R15]
        sel_at_row = (cmd_q == CMD_LOAD_MASK || cmd_q == CMD_LOAD_COLOR);
        // Select at column fall: high for block writes and color load [R16] [R19]
        sel_at_col = (cmd_q == CMD_BLOCK_WRITE || cmd_q == CMD_MASKED_BLOCK || cmd_q == CMD_LOAD_COLOR);
        // Write enable low at row fall only for masked kinds [R4] [R19]
        we_at_row = masked;
    end

    // Next pin levels; every pin leaves a flop so decode glitches never reach a strobe
    logic                 row_stb_n_d, row_stb_n_q, col_stb_n_d, col_stb_n_q;
    logic                 we_n_d, we_n_q, wl_n_d, wl_n_q, wu_n_d, wu_n_q;  // Write enable, byte strobes
    logic                 oe_n_d, oe_n_q, sel_d, sel_q;                    // Output enable, select
    logic [ADDR_W-1:0]    addr_d, addr_q;
    logic [DATA_W-1:0]    pins_out_d, pins_out_q;
    logic                 pins_oe_n_d, pins_oe_n_q;                        // Low while host drives
    always_comb begin
        row_stb_n_d = !row_low;
        col_stb_n_d = !col_low;                          // High in row-only refresh [R22]
        // Option-reset refresh drops column first with select low [R23]
        if (!refr_q && cmd_q == CMD_OPTION_RESET && state_q != S_IDLE && state_q != S_PRE)
            col_stb_n_d = 1'b0;
        addr_d = (state_q == S_ROW || state_q == S_IDLE) ? row_q : col_q;
        sel_d = 1'b0;
        we_n_d = 1'b1;                                   // Stays high through reads [R24]
        wl_n_d = 1'b1;
        wu_n_d = 1'b1;
        pins_out_d = 16'h0000;
        pins_oe_n_d = 1'b1;
        oe_n_d = 1'b1;
        if (!refr_q && cmd_q != CMD_OPTION_RESET) begin
            if (state_q == S_ROW) begin
                sel_d = sel_at_row;
                if (we_at_row) begin
                    // Fresh plane mask each row cycle [R4] [R6]; 0 blocks a bit [R5]
                    we_n_d = 1'b0;
                    wl_n_d = 1'b0;
                    wu_n_d = 1'b0;
                    pins_out_d = mask_q;
                    pins_oe_n_d = 1'b0;
                end
                // Otherwise both byte strobes high: no masking [R8]
            end else if (state_q == S_COL || state_q == S_HOLD) begin
                sel_d = sel_at_col;
                if (is_write) begin
                    // Early write: strobes low before column fall [R7]; per-lane [R3] [R9]
                    we_n_d = 1'b0;
                    wl_n_d = !lanes_q[0];
                    wu_n_d = !lanes_q[1];
                    // Block writes drive per-column enables [R18]
                    pins_out_d = data_q;
                    pins_oe_n_d = 1'b0;
                end else begin
                    oe_n_d = 1'b0;                       // Device drives only when enabled [R1] [R20]
                end
            end
        end
    end

    // Pin flops: idle levels during reset, all pins move together on the edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            row_stb_n_q <= 1'b1; col_stb_n_q <= 1'b1; we_n_q <= 1'b1; wl_n_q <= 1'b1; wu_n_q <= 1'b1;
            oe_n_q <= 1'b1; sel_q <= 1'b0; addr_q <= 9'h000; pins_out_q <= 16'h0000; pins_oe_n_q <= 1'b1;
        end else begin
            row_stb_n_q <= row_stb_n_d; col_stb_n_q <= col_stb_n_d; we_n_q <= we_n_d; wl_n_q <= wl_n_d;
            wu_n_q <= wu_n_d; oe_n_q <= oe_n_d; sel_q <= sel_d; addr_q <= addr_d;
            pins_out_q <= pins_out_d; pins_oe_n_q <= pins_oe_n_d;
        end
    end

    assign row_strobe_n                  = row_stb_n_q;
    assign col_strobe_n                  = col_stb_n_q;
    assign write_enable_or_mask_select_n = we_n_q;
    assign lower_byte_write_strobe_n     = wl_n_q;
    assign upper_byte_write_strobe_n     = wu_n_q;
    assign transfer_or_output_enable_n   = oe_n_q;
    assign special_function_select       = sel_q;
    assign addr                          = addr_q;
    assign mask_and_data_pins_out        = pins_out_q;
    assign mask_and_data_pins_oe_n       = pins_oe_n_q;
    assign req_ready = (state_q == S_IDLE) && !rpend_q;
    assign rd_valid  = rdv_q;
    assign rd_data   = rdd_q;

    // ==========================================================
    // Checks
    a_pins_float_read: assert property (@(posedge mclk) disable iff (!rst_n)
        !transfer_or_output_enable_n |-> mask_and_data_pins_oe_n)
        else $error("host drives pins while device output enabled"); // [R20]
    a_refresh_col_high: assert property (@(posedge mclk) disable iff (!rst_n)
        refr_q && !row_strobe_n |-> col_strobe_n)
        else $error("column strobe low during row-only refresh"); // [R22]
    a_read_we_high: assert property (@(posedge mclk) disable iff (!rst_n)
        !refr_q && cmd_q == CMD_READ |-> write_enable_or_mask_select_n)
        else $error("write enable low in read"); // [R24]
    a_block_low_bits: assert property (@(posedge mclk) disable iff (!rst_n)
        !col_strobe_n && (cmd_q == CMD_BLOCK_WRITE || cmd_q == CMD_MASKED_BLOCK) |-> addr[2:0] == 3'b000)
        else $error("block write low column bits not zero"); // [R17]
    a_mask_at_row: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(row_strobe_n) && masked && !refr_q |-> !write_enable_or_mask_select_n
        && !special_function_select && col_strobe_n && mask_and_data_pins_out == mask_q)
        else $error("masked write setup wrong at row fall"); // [R4]
    a_load_row_sel: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(row_strobe_n) && !refr_q && cmd_q == CMD_LOAD_MASK |->
        special_function_select && write_enable_or_mask_select_n)
        else $error("mask load setup wrong"); // [R10]
    a_color_col_sel: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(col_strobe_n) && !refr_q && cmd_q == CMD_LOAD_COLOR |-> special_function_select)
        else $error("color load select low at column fall"); // [R15]
    a_lane_strobe: assert property (@(posedge mclk) disable iff (!rst_n)
        !col_strobe_n && is_write |-> lower_byte_write_strobe_n == !lanes_q[0]
        && upper_byte_write_strobe_n == !lanes_q[1])
        else $error("byte strobe does not follow lanes"); // [R9]
    a_refresh_bound: assert property (@(posedge mclk) disable iff (!rst_n)
        rtmr_q < 32'(REFRESH_CYCLES))
        else $error("refresh timer overran"); // [R21]
    // An owed refresh waits at most one user cycle before its row strobe falls
    sequence s_refresh_row;
        refr_q && !row_strobe_n;
    endsequence
    a_refresh_served: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(rpend_q) |-> ##[1:40] s_refresh_row)
        else $error("owed refresh not started in time"); // [R21]
endmodule // vram_ctl

// ==== vram_ctl_pkg.sv ====
// Constants and types shared by the video DRAM random-port controller
package vram_ctl_pkg;
    // ==========================================================
    // Clock and timing
    localparam int CLK_PERIOD_PS    = 8000;            // 125 MHz clock
    localparam int STEP_NS          = 40;              // Least strobe phase length
    localparam int STEP_CYCLES      = (STEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int REFRESH_MS       = 8;               // Whole-array refresh window
    localparam int ROW_COUNT        = 512;             // Rows to refresh per window
    // Divided by the row count before the last scaling so the product stays inside 32 bits
    localparam int REFRESH_INTERVAL = (REFRESH_MS * 1000 * 1000 / ROW_COUNT) * 1000 / CLK_PERIOD_PS;
    // ==========================================================
    // Widths
    localparam int ADDR_W = 9;                         // Multiplexed address pins
    localparam int DATA_W = 16;                        // Mask and data pins
    localparam int ROW_W  = 9;
    localparam logic [ADDR_W-1:0] BLOCK_COL_MASK = 9'h1F8;  // Block write ignores low 3 bits
    // ==========================================================
    // Commands from the user side
    typedef enum logic [2:0] {
        CMD_READ, CMD_WRITE, CMD_MASKED_WRITE, CMD_LOAD_MASK,
        CMD_LOAD_COLOR, CMD_BLOCK_WRITE, CMD_MASKED_BLOCK, CMD_OPTION_RESET
    } cmd_t;
endpackage

// ==== vram_ctl_tb.sv ====
// Self-checking bench for the video DRAM random-port controller
`timescale 1ns/1ps
module vram_ctl_tb;
    import vram_ctl_pkg::*;
    // ==========================================
    // Signals
    logic        mclk = 1'b0, rst_n = 1'b0, req_valid = 1'b0;
    logic        req_ready, rd_valid, rstb_n, cstb_n, we_n, wl_n, wu_n, oe_n, sf, host_oe_n;
    cmd_t        req_cmd = CMD_READ;
    logic [8:0]  req_row = 9'h000, req_col = 9'h000, addr, ref_row = 9'h000;
    logic [15:0] req_mask = 16'h0000, req_data = 16'h0000, rd_data, host_out, dq_q, pins;
    logic [1:0]  req_lanes = 2'b11;
    int          n_mismatch = 0, checks_done = 0, n_ref = 0, n_same = 0;
    // Wire level: host when its enable is low, else the model
    assign pins = !host_oe_n ? host_out : dq_q;
    vram_ctl #(.REFRESH_CYCLES(100)) vram_ctl_i (
        .mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
        .req_cmd(req_cmd), .req_row(req_row), .req_col(req_col), .req_mask(req_mask),
        .req_data(req_data), .req_lanes(req_lanes), .rd_valid(rd_valid), .rd_data(rd_data),
        .row_strobe_n(rstb_n), .col_strobe_n(cstb_n), .write_enable_or_mask_select_n(we_n),
        .lower_byte_write_strobe_n(wl_n), .upper_byte_write_strobe_n(wu_n),
        .transfer_or_output_enable_n(oe_n), .special_function_select(sf), .addr(addr),
        .mask_and_data_pins_in(pins), .mask_and_data_pins_out(host_out),
        .mask_and_data_pins_oe_n(host_oe_n));
    vram_dev_model vram_dev_model_i (
        .rstb_n(rstb_n), .cstb_n(cstb_n), .we_n(we_n), .wl_n(wl_n), .wu_n(wu_n),
        .oe_n(oe_n), .sf(sf), .addr(addr), .pins(pins), .dq_q(dq_q));
    // ==========================================
    // Clock and row-strobe monitor
    initial forever #4 mclk = ~mclk;
    // Counts row strobes with column high; a repeated row is a stuck counter
    always @(negedge rstb_n) if (cstb_n === 1'b1) begin
        if (n_ref > 0 && addr === ref_row) n_same++;
        n_ref++;
        ref_row = addr;
    end
    // ==========================================
    // Shared tasks
    task automatic chk(input logic [15:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Offer a command and hold it until the edge that takes it
    task automatic cmd(input cmd_t c, input logic [8:0] r, col, input logic [15:0] m, d,
                       input logic [1:0] l);
        int n = 0;
        @(negedge mclk);
        {req_cmd, req_row, req_col, req_mask, req_data, req_lanes} = {c, r, col, m, d, l};
        req_valid = 1'b1;
        while (req_ready !== 1'b1 && n < 2000) begin
            @(negedge mclk);
            n++;
        end
        @(negedge mclk);
        req_valid = 1'b0;
        if (n >= 2000) n_mismatch++;
    endtask
    // Read one word and compare the returned value
    task automatic rd(input logic [8:0] r, c, input logic [15:0] exp);
        int n = 0;
        cmd(CMD_READ, r, c, 16'h0000, 16'h0000, 2'b11);
        while (rd_valid !== 1'b1 && n < 100) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 100) n_mismatch++;
        chk(rd_data, exp);
    endtask
    // ==========================================
    // Scenarios
    task automatic t_write();
        cmd(CMD_WRITE, 9'h003, 9'h040, 16'h0000, 16'h1234, 2'b11);
        rd(9'h003, 9'h040, 16'h1234);
        cmd(CMD_WRITE, 9'h003, 9'h040, 16'h0000, 16'hABCD, 2'b01);
        rd(9'h003, 9'h040, 16'h12CD);
        cmd(CMD_WRITE, 9'h003, 9'h040, 16'h0000, 16'h5678, 2'b10);
        rd(9'h003, 9'h040, 16'h56CD);
        $display("Test write done");
    endtask
    task automatic t_new_mask();
        cmd(CMD_MASKED_WRITE, 9'h003, 9'h041, 16'h00FF, 16'hFFFF, 2'b11);
        rd(9'h003, 9'h041, 16'h00FF);
        cmd(CMD_MASKED_WRITE, 9'h003, 9'h041, 16'hF000, 16'hFFFF, 2'b11);
        rd(9'h003, 9'h041, 16'hF0FF);
        $display("Test new mask done");
    endtask
    task automatic t_old_mask();
        cmd(CMD_LOAD_MASK, 9'h004, 9'h000, 16'h0F0F, 16'h0F0F, 2'b11);
        cmd(CMD_MASKED_WRITE, 9'h004, 9'h042, 16'hFFFF, 16'hFFFF, 2'b11);
        rd(9'h004, 9'h042, 16'h0F0F);
        cmd(CMD_WRITE, 9'h004, 9'h043, 16'h0000, 16'h1111, 2'b11);
        cmd(CMD_MASKED_WRITE, 9'h004, 9'h044, 16'hF0F0, 16'hFFFF, 2'b11);
        rd(9'h004, 9'h044, 16'h0F0F);
        cmd(CMD_OPTION_RESET, 9'h000, 9'h000, 16'h0000, 16'h0000, 2'b11);
        cmd(CMD_MASKED_WRITE, 9'h004, 9'h045, 16'hF0F0, 16'hFFFF, 2'b11);
        rd(9'h004, 9'h045, 16'hF0F0);
        $display("Test old mask done");
    endtask
    task automatic t_block();
        logic [15:0] exp [3] = '{16'hA5C3, 16'hA500, 16'hA5C3};
        cmd(CMD_LOAD_COLOR, 9'h005, 9'h000, 16'hA5C3, 16'hA5C3, 2'b11);
        cmd(CMD_BLOCK_WRITE, 9'h005, 9'h015, 16'hFFFF, 16'h0005, 2'b11);
        cmd(CMD_MASKED_BLOCK, 9'h005, 9'h010, 16'hFF00, 16'h0002, 2'b11);
        for (int i = 0; i < 3; i++) rd(9'h005, 9'h010 + 9'(i), exp[i]);
        rd(9'h005, 9'h013, 16'h0000);
        $display("Test block done");
    endtask
    task automatic t_refresh();
        n_ref = 0;
        n_same = 0;
        repeat (450) @(negedge mclk);
        chk({15'h0000, n_ref >= 4 && n_ref <= 5}, 16'h0001);
        chk(16'(n_same), 16'h0000);
        $display("Test refresh done");
    endtask
    task automatic finish_test();
        $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ==========================================
    // Main sequence and watchdog
    initial begin
        repeat (5) @(negedge mclk);
        rst_n = 1'b1;
        t_write();
        t_new_mask();
        t_old_mask();
        t_block();
        t_refresh();
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        finish_test();
    end
endmodule // vram_ctl_tb

// ==== vram_dev_model.sv ====
// Behavioural model of the video DRAM random-access port
`timescale 1ns/1ps
module vram_dev_model (
    input  wire logic        rstb_n,
    input  wire logic        cstb_n,
    input  wire logic        we_n,
    input  wire logic        wl_n,
    input  wire logic        wu_n,
    input  wire logic        oe_n,
    input  wire logic        sf,
    input  wire logic [8:0]  addr,
    input  wire logic [15:0] pins,
    output logic      [15:0] dq_q
);
    // ==========================================
    // Array and mode state
    logic [15:0] mem [bit [17:0]];        // Sparse array, row then column
    logic [15:0] mask_q, color_q, pmask;  // Stored mask, colour, plane mask
    logic [15:0] be, last = 16'h0000;     // Lane enables, last word driven
    logic [8:0]  row;                     // Row latched at row strobe fall
    logic        old_mode = 1'b0;         // Starts in new mask mode
    logic        sf_r, masked, rd_on = 1'b0;
    // Merge a word under a bit enable; unwritten cells read as zero
    task automatic put(input logic [17:0] k, input logic [15:0] d, en);
        mem[k] = ((mem.exists(k) ? mem[k] : 16'h0000) & ~en) | (d & en);
    endtask
    // Released pins show the inverse, so a stale value never passes
    assign dq_q = (rd_on && !oe_n && we_n) ? last : ~last;
    // Cycle type decoded at the row strobe fall
    always @(negedge rstb_n) begin
        if (!cstb_n) begin
            if (!sf) old_mode = 1'b0;  // Option-reset refresh
        end else begin
            row = addr;                 // Row-only refresh lands here too
            sf_r = sf;
            masked = !we_n && !sf && !(wl_n && wu_n);
            pmask = !masked ? 16'hFFFF : old_mode ? mask_q : pins;
        end
    end
    // Column strobe fall: early writes sample data here
    always @(negedge cstb_n) if (!rstb_n) begin
        be = {{8{!wu_n}}, {8{!wl_n}}};  // Byte lanes
        if (sf_r && !sf) begin
            mask_q = (mask_q & ~be) | (pins & be);  // Byte lanes apply
            old_mode = 1'b1;
        end else if (sf_r) begin
            color_q = (color_q & ~be) | (pins & be);
        end else if (sf) begin
            for (int i = 0; i < 8; i++)
                if (pins[i]) put({row, addr[8:3], i[2:0]}, color_q, pmask & be);
        end else if (!we_n) begin
            put({row, addr}, pins, pmask & be);
        end else begin
            last = mem.exists({row, addr}) ? mem[{row, addr}] : 16'h0000;
            rd_on = 1'b1;
        end
    end
    // Output released once both strobes are high
    always @(posedge rstb_n or posedge cstb_n) if (rstb_n && cstb_n) rd_on = 1'b0;
endmodule // vram_dev_model
